// [design/bdr_decode.sv]
// Purpose: Board address decode, I/O register steering and serial framing helpers.
// Assumes: One processor cycle per strobe; inputs synchronous to clk_sys.
// Notes: Selects and strobes are registered, so they lag the cycle by one edge.
// Function
// - ROM decoded from zero, size by strap
// - 4K RAM window ends on 16K boundary
// - Serial rate register decoded at DE
// - Rate factor loaded low then high byte
// - Controller registers decoded at DA and DB
// - Shared addresses resolved by sequence and bit
// - Timer counts assembled from two writes
// - 5-8 bit chars, break, selectable stops
// - Reject start bits that do not persist
// - Sync mode inserts sync characters automatically unless ext_sync
`timescale 1ns/10ps
module bdr_decode
   import bdr_pkg::*;
#(
   parameter int FACTOR_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rom_large,
   input wire logic [1:0] ram_bank,
   input wire bdr_cycle_t cyc,
   input wire bdr_ser_cfg_t ser_cfg,
   input wire logic rx_line,
   input wire logic tx_empty,
   output bdr_sel_t sel_reg,
   output bdr_ic_target_t ic_target_reg,
   output logic [7:0] rd_data_reg,
   output logic rd_data_valid_reg,
   output logic [FACTOR_W-1:0] rate_factor_reg,
   output logic rate_valid_reg,
   output logic [15:0] tmr0_count_reg,
   output logic tmr0_valid_reg,
   output logic [15:0] tmr1_count_reg,
   output logic tmr1_valid_reg,
   output logic [7:0] tmr_ctl_reg,
   output logic [7:0] ic_mask_reg,
   output logic [7:0] ic_vector_reg,
   output logic ser_tick_reg,
   output logic start_ok_reg,
   output logic false_start_reg,
   output logic tx_line_reg,
   output logic sync_insert_reg,
   output logic [4:0] frame_halfbits_reg
);

   initial begin
      if (FACTOR_W != 16) begin
         $error("FACTOR_W must be 16: the factor is two bytes.");
      end
   end

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   // True for an I/O cycle aimed at one register address.
   function automatic logic io_hit(input bdr_cycle_t c, input logic [7:0] a);
      io_hit = (c.io_rd || c.io_wr) && (c.addr[7:0] == a);
   endfunction

   logic rom_large_reg;
   logic [1:0] ram_bank_reg;
   logic [15:0] ram_base;
   logic [15:0] rom_top;
   logic mem_cyc;
   bdr_sel_t sel_next;

   // Straps are caught after reset release so an async path never loads a pin.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rom_large_reg <= 1'b0;
         ram_bank_reg <= BDR_RAM_BANK_RESET;
      end else begin
         rom_large_reg <= rom_large;
         ram_bank_reg <= ram_bank;
      end
   end

   // Window bounds follow the straps.
   always_comb begin
      rom_top = rom_large_reg ? BDR_ROM_TOP_LARGE : BDR_ROM_TOP_SMALL;
      ram_base = 16'((int'(ram_bank_reg) + 1) * BDR_RAM_ALIGN - BDR_RAM_BYTES);
      mem_cyc = cyc.mem_rd || cyc.mem_wr;
   end

   // Chip selects; anything not matched stays low for expansion boards.
   always_comb begin
      sel_next = '0;
      sel_next.rom = cyc.mem_rd && (cyc.addr <= rom_top);
      sel_next.ram = mem_cyc && (cyc.addr[15:12] == ram_base[15:12]);
      sel_next.ic = io_hit(cyc, BDR_IO_IC_A) || io_hit(cyc, BDR_IO_IC_B);
      sel_next.tmr0 = io_hit(cyc, BDR_IO_TMR0);
      sel_next.tmr1 = io_hit(cyc, BDR_IO_TMR1);
      sel_next.tctl = io_hit(cyc, BDR_IO_TCTL);
      sel_next.rate = io_hit(cyc, BDR_IO_RATE);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sel_reg <= '0;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // ---------------------------------------------------------------
   // Two-write loaders
   // ---------------------------------------------------------------
   logic rate_hi_reg;
   logic [7:0] rate_lo_reg;
   logic wr_rate;

   assign wr_rate = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_RATE);

   // Factor goes live only once the high byte lands after a low byte.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rate_hi_reg <= 1'b0;
         rate_lo_reg <= 8'h00;
         rate_factor_reg <= '0;
         rate_valid_reg <= 1'b0;
      end else if (wr_rate) begin
         rate_hi_reg <= !rate_hi_reg;
         if (!rate_hi_reg) begin
            rate_lo_reg <= cyc.data;
         end else begin
            rate_factor_reg <= {cyc.data, rate_lo_reg};
            rate_valid_reg <= 1'b1;
         end
      end
   end

   logic wr_tctl;
   logic [1:0] tmr_hi_reg;
   logic [1:0][7:0] tmr_lo_reg;
   logic [1:0] wr_tmr;

   assign wr_tctl = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_TCTL);
   assign wr_tmr[0] = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_TMR0);
   assign wr_tmr[1] = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_TMR1);

   // A control write restarts byte order so a half-loaded count cannot skew.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tmr_ctl_reg <= 8'h00;
      end else if (wr_tctl) begin
         tmr_ctl_reg <= cyc.data;
      end
   end

   generate
      for (genvar t = 0; t < 2; t++) begin : g_tmr
         always_ff @(posedge clk_sys) begin
            if (reset || wr_tctl) begin
               tmr_hi_reg[t] <= 1'b0;
            end else if (wr_tmr[t]) begin
               tmr_hi_reg[t] <= !tmr_hi_reg[t];
            end
         end
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               tmr_lo_reg[t] <= 8'h00;
            end else if (wr_tmr[t] && !tmr_hi_reg[t]) begin
               tmr_lo_reg[t] <= cyc.data;
            end
         end
      end
   endgenerate

   // Assembled counts.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tmr0_count_reg <= 16'h0000;
         tmr0_valid_reg <= 1'b0;
         tmr1_count_reg <= 16'h0000;
         tmr1_valid_reg <= 1'b0;
      end else begin
         if (wr_tmr[0] && tmr_hi_reg[0]) begin
            tmr0_count_reg <= {cyc.data, tmr_lo_reg[0]};
            tmr0_valid_reg <= 1'b1;
         end
         if (wr_tmr[1] && tmr_hi_reg[1]) begin
            tmr1_count_reg <= {cyc.data, tmr_lo_reg[1]};
            tmr1_valid_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt controller register steering
   // ---------------------------------------------------------------
   logic expect_vec_reg;
   logic read_svc_reg;
   logic poll_armed_reg;
   bdr_ic_target_t ic_next;
   logic wr_a;
   logic wr_b;
   logic rd_a;
   logic rd_b;

   assign wr_a = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_IC_A);
   assign wr_b = cyc.io_wr && (cyc.addr[7:0] == BDR_IO_IC_B);
   assign rd_a = cyc.io_rd && (cyc.addr[7:0] == BDR_IO_IC_A);
   assign rd_b = cyc.io_rd && (cyc.addr[7:0] == BDR_IO_IC_B);

   // Which register answers depends on earlier accesses and one data bit.
   always_comb begin
      ic_next = BDR_IC_NONE;
      if (wr_a) begin
         ic_next = cyc.data[BDR_IC_INIT_BIT] ? BDR_IC_INIT : BDR_IC_CMD;
      end else if (wr_b) begin
         ic_next = expect_vec_reg ? BDR_IC_VECTOR : BDR_IC_MASK_WR;
      end else if (rd_a) begin
         if (poll_armed_reg) begin
            ic_next = BDR_IC_RD_POLL;
         end else begin
            ic_next = read_svc_reg ? BDR_IC_RD_SVC : BDR_IC_RD_REQ;
         end
      end else if (rd_b) begin
         ic_next = BDR_IC_RD_MASK;
      end
   end

   // Sequence state: init arms the vector write, read commands pick a view.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         expect_vec_reg <= 1'b0;
         read_svc_reg <= 1'b0;
         poll_armed_reg <= 1'b0;
      end else begin
         if (wr_a && cyc.data[BDR_IC_INIT_BIT]) begin
            expect_vec_reg <= 1'b1;
         end else if (wr_b) begin
            expect_vec_reg <= 1'b0;
         end
         if (wr_a && !cyc.data[BDR_IC_INIT_BIT] && cyc.data[BDR_IC_OCW3_BIT]) begin
            if (cyc.data[BDR_IC_RR_BIT]) begin
               read_svc_reg <= cyc.data[BDR_IC_RIS_BIT];
            end
            poll_armed_reg <= cyc.data[BDR_IC_POLL_BIT];
         end else if (rd_a) begin
            poll_armed_reg <= 1'b0; // A poll read is one-shot.
         end
      end
   end

   // Mask and vector copies; the mask is readable back at the second address.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ic_target_reg <= BDR_IC_NONE;
         ic_mask_reg <= BDR_MASK_RESET;
         ic_vector_reg <= 8'h00;
         rd_data_reg <= 8'h00;
         rd_data_valid_reg <= 1'b0;
      end else begin
         ic_target_reg <= ic_next;
         rd_data_valid_reg <= rd_b;
         rd_data_reg <= rd_b ? ic_mask_reg : 8'h00;
         if (ic_next == BDR_IC_MASK_WR) begin
            ic_mask_reg <= cyc.data;
         end
         if (ic_next == BDR_IC_VECTOR) begin
            ic_vector_reg <= cyc.data;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial bit clock and framing
   // ---------------------------------------------------------------
   logic [FACTOR_W-1:0] div_cnt_reg;
   logic [FACTOR_W-1:0] half_cnt_reg;
   logic rx_prev_reg;
   logic hunt_reg;

   // Bit clock divides clk_sys by the loaded factor; idle until loaded.
   always_ff @(posedge clk_sys) begin
      if (reset || !rate_valid_reg || (wr_rate && rate_hi_reg)) begin
         div_cnt_reg <= '0;
         ser_tick_reg <= 1'b0;
      end else if (div_cnt_reg == '0) begin
         div_cnt_reg <= rate_factor_reg - FACTOR_W'(1);
         ser_tick_reg <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg - FACTOR_W'(1);
         ser_tick_reg <= 1'b0;
      end
   end

   // A falling edge is rechecked half a bit later; a glitch is only noise.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_prev_reg <= 1'b1;
         hunt_reg <= 1'b0;
         half_cnt_reg <= '0;
         start_ok_reg <= 1'b0;
         false_start_reg <= 1'b0;
      end else begin
         rx_prev_reg <= rx_line;
         start_ok_reg <= 1'b0;
         false_start_reg <= 1'b0;
         if (!hunt_reg) begin
            if (rx_prev_reg && !rx_line && !ser_cfg.sync_mode && rate_valid_reg) begin
               hunt_reg <= 1'b1;
               half_cnt_reg <= rate_factor_reg >> 1;
            end
         end else if (rx_line) begin
            hunt_reg <= 1'b0;
            false_start_reg <= 1'b1;
         end else if (half_cnt_reg <= FACTOR_W'(1)) begin
            hunt_reg <= 1'b0;
            start_ok_reg <= 1'b1;
         end else begin
            half_cnt_reg <= half_cnt_reg - FACTOR_W'(1);
         end
      end
   end

   // Frame length in half bits; break holds the line low in async mode.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_line_reg <= 1'b1;
         frame_halfbits_reg <= 5'h00;
      end else begin
         tx_line_reg <= !(ser_cfg.brk && !ser_cfg.sync_mode);
         if (ser_cfg.sync_mode) begin
            frame_halfbits_reg <= 5'((BDR_CHAR_MIN + int'(ser_cfg.char_len)) * 2);
         end else begin
            unique case (ser_cfg.stop_sel)
               BDR_STOP_1P5: frame_halfbits_reg <=
                  5'((1 + BDR_CHAR_MIN + int'(ser_cfg.char_len)) * 2 + 3);
               BDR_STOP_2: frame_halfbits_reg <=
                  5'((1 + BDR_CHAR_MIN + int'(ser_cfg.char_len)) * 2 + 4);
               default: frame_halfbits_reg <=
                  5'((1 + BDR_CHAR_MIN + int'(ser_cfg.char_len)) * 2 + 2);
            endcase
         end
      end
   end

   // With nothing to send in sync mode, and ext_sync low, the line is filled with sync characters.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_insert_reg <= 1'b0;
      end else begin
         sync_insert_reg <= ser_cfg.sync_mode && !ser_cfg.ext_sync && tx_empty
            && ser_tick_reg;
      end
   end

endmodule

// [include/bdr_pkg.sv]
// Purpose: Shared constants and carriers for the board address decoder.
// Assumes: 16-bit memory addresses and 8-bit I/O addresses from one processor.
// Notes: I/O addresses are compared on the low address byte only.
package bdr_pkg;

   // ---------------------------------------------------------------
   // Memory windows
   // ---------------------------------------------------------------
   localparam logic [15:0] BDR_ROM_TOP_SMALL = 16'h0FFF;
   localparam logic [15:0] BDR_ROM_TOP_LARGE = 16'h1FFF;
   localparam int BDR_RAM_BYTES = 4096;
   localparam int BDR_RAM_ALIGN = 16384;
   localparam logic [1:0] BDR_RAM_BANK_RESET = 2'h3;

   // ---------------------------------------------------------------
   // I/O register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] BDR_IO_IC_A = 8'hDA;
   localparam logic [7:0] BDR_IO_IC_B = 8'hDB;
   localparam logic [7:0] BDR_IO_TMR0 = 8'hDC;
   localparam logic [7:0] BDR_IO_TMR1 = 8'hDD;
   localparam logic [7:0] BDR_IO_RATE = 8'hDE;
   localparam logic [7:0] BDR_IO_TCTL = 8'hDF;

   // ---------------------------------------------------------------
   // Interrupt controller control word bits
   // ---------------------------------------------------------------
   localparam int BDR_IC_INIT_BIT = 4;
   localparam int BDR_IC_OCW3_BIT = 3;
   localparam int BDR_IC_POLL_BIT = 2;
   localparam int BDR_IC_RR_BIT = 1;
   localparam int BDR_IC_RIS_BIT = 0;
   localparam logic [7:0] BDR_MASK_RESET = 8'hFF;

   // ---------------------------------------------------------------
   // Serial format codes
   // ---------------------------------------------------------------
   localparam int BDR_CHAR_MIN = 5;
   localparam logic [1:0] BDR_STOP_1 = 2'h1;
   localparam logic [1:0] BDR_STOP_1P5 = 2'h2;
   localparam logic [1:0] BDR_STOP_2 = 2'h3;

   typedef enum logic [3:0] {
      BDR_IC_NONE,
      BDR_IC_INIT,
      BDR_IC_CMD,
      BDR_IC_VECTOR,
      BDR_IC_MASK_WR,
      BDR_IC_RD_REQ,
      BDR_IC_RD_SVC,
      BDR_IC_RD_POLL,
      BDR_IC_RD_MASK
   } bdr_ic_target_t;

   typedef struct packed {
      logic [15:0] addr;
      logic mem_rd;
      logic mem_wr;
      logic io_rd;
      logic io_wr;
      logic [7:0] data;
   } bdr_cycle_t;

   typedef struct packed {
      logic rom;
      logic ram;
      logic ic;
      logic tmr0;
      logic tmr1;
      logic tctl;
      logic rate;
   } bdr_sel_t;

   typedef struct packed {
      logic sync_mode;
      logic [1:0] char_len;
      logic [1:0] stop_sel;
      logic brk;
      logic ext_sync;
   } bdr_ser_cfg_t;

endpackage

// [tb/bdr_cpu_model.sv]
// Purpose: Processor model issuing one memory or I/O access per cycle.
// Assumes: Caller keeps the low byte before the high byte of paired loads.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/10ps
module bdr_cpu_model
   import bdr_pkg::*;
(
   input wire logic clk_sys,
   output bdr_cycle_t cyc
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // Kind 0 memory read, 1 memory write, 2 I/O read, 3 I/O write.
   initial cyc = '0;
   task automatic acc(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data);
      @(negedge clk_sys);
      cyc <= '{addr, kind == 2'h0, kind == 2'h1, kind == 2'h2, kind == 2'h3,
         kind[0] ? data : ~cyc.data};
   endtask
   // Idle keeps stale values off the bus so nothing decodes them by luck.
   task automatic idle();
      @(negedge clk_sys);
      cyc <= '{~cyc.addr, 1'b0, 1'b0, 1'b0, 1'b0, ~cyc.data};
   endtask
endmodule

// [tb/bdr_decode_monitor.sv]
// Purpose: Port-level checks of the board decoder.
// Assumes: Straps are held steady around the accesses they qualify.
// Notes: Outputs are judged one edge after the access that caused them.
`timescale 1ns/10ps
module bdr_decode_monitor
   import bdr_pkg::*;
#(
   parameter int FACTOR_W = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rom_large,
   input wire logic [1:0] ram_bank,
   input wire bdr_cycle_t cyc,
   input wire bdr_sel_t sel_reg,
   input wire bdr_ic_target_t ic_target_reg,
   input wire logic [7:0] rd_data_reg,
   input wire logic rd_data_valid_reg,
   input wire logic [FACTOR_W-1:0] rate_factor_reg,
   input wire logic rate_valid_reg,
   input wire logic [15:0] tmr0_count_reg,
   input wire logic [7:0] ic_mask_reg
);
   // ---------------------------------------------------------------
   // Expected hits
   // ---------------------------------------------------------------
   // Decoded from the cycle itself so each expected hit needs only one $past.
   logic ram_hit;
   logic rate_hit;
   logic [3:0] io_exp;
   assign ram_hit = cyc.addr[15:12] == {ram_bank, 2'h3};
   assign rate_hit = cyc.io_wr && cyc.addr[7:0] == BDR_IO_RATE;
   assign io_exp = {4{cyc.io_wr}} & {cyc.addr[7:1] == 7'h6D, cyc.addr[7:0] == BDR_IO_TMR0,
      cyc.addr[7:0] == BDR_IO_TMR1, cyc.addr[7:0] == BDR_IO_TCTL};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // All checks share the system clock and are silenced during reset.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_rom_small; cyc.mem_rd && cyc.addr <= 16'h0FFF |=> sel_reg.rom; endproperty
   a_rom_small: assert property (p_rom_small) else $error("low ROM not selected");
   property p_rom_large;
      cyc.mem_rd && cyc.addr[15:12] == 4'h1 && $stable(rom_large) && !$past(reset)
         |=> sel_reg.rom == $past(rom_large);
   endproperty
   a_rom_large: assert property (p_rom_large) else $error("ROM size strap ignored");
   property p_rom_off; cyc.addr > 16'h1FFF || !cyc.mem_rd |=> !sel_reg.rom; endproperty
   a_rom_off: assert property (p_rom_off) else $error("ROM selected off window");
   property p_ram;
      (cyc.mem_rd || cyc.mem_wr) && $stable(ram_bank) && !$past(reset)
         |=> sel_reg.ram == $past(ram_hit);
   endproperty
   a_ram: assert property (p_ram) else $error("RAM window decode wrong");
   property p_io; cyc.io_wr |=> {sel_reg.ic, sel_reg.tmr0, sel_reg.tmr1, sel_reg.tctl} ==
      $past(io_exp) && sel_reg.rate == $past(rate_hit); endproperty
   a_io: assert property (p_io) else $error("I/O select wrong");
   property p_rate_load; !$past(reset) && $changed(rate_factor_reg) |-> $past(rate_hit)
      && rate_valid_reg && rate_factor_reg[FACTOR_W-1:8] == $past(cyc.data); endproperty
   a_rate_load: assert property (p_rate_load) else $error("rate factor load wrong");
   property p_tmr_load; !$past(reset) && $changed(tmr0_count_reg) |->
      $past(io_exp[2]) && tmr0_count_reg[15:8] == $past(cyc.data); endproperty
   a_tmr_load: assert property (p_tmr_load) else $error("timer count load wrong");
   property p_mask; !$past(reset) && $changed(ic_mask_reg) |->
      $past(cyc.io_wr) && ic_mask_reg == $past(cyc.data); endproperty
   a_mask: assert property (p_mask) else $error("mask changed without write");
   property p_rdback; cyc.io_rd && cyc.addr[7:0] == BDR_IO_IC_B |=> rd_data_valid_reg &&
      rd_data_reg == $past(ic_mask_reg) && ic_target_reg == BDR_IC_RD_MASK; endproperty
   a_rdback: assert property (p_rdback) else $error("mask read back wrong");
   c_rate: cover property ($rose(rate_valid_reg));
   c_vec: cover property (ic_target_reg == BDR_IC_VECTOR);
   c_ram: cover property (sel_reg.ram);
endmodule

bind bdr_decode bdr_decode_monitor #(.FACTOR_W(FACTOR_W)) bdr_decode_monitor_i (.clk_sys,
   .reset, .rom_large, .ram_bank, .cyc, .sel_reg, .ic_target_reg, .rd_data_reg,
   .rd_data_valid_reg, .rate_factor_reg, .rate_valid_reg, .tmr0_count_reg, .ic_mask_reg);

// [tb/board_address_decode_regmap_tb_top.sv]
// Purpose: Directed tests of the board decoder through processor cycles.
// Assumes: Serial inputs idle high until the serial test drives them.
// Notes: Each check is taken at the falling edge after the answering edge.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module board_address_decode_regmap_tb_top
   import bdr_pkg::*;
;
   localparam logic [1:0] MR = 2'h0;
   localparam logic [1:0] MW = 2'h1;
   localparam logic [1:0] IR = 2'h2;
   localparam logic [1:0] IW = 2'h3;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic rom_large = 1'b0;
   logic [1:0] ram_bank = 2'h3;
   bdr_cycle_t cyc;
   bdr_sel_t sel_reg;
   bdr_ic_target_t ic_target_reg;
   logic [7:0] rd_data_reg, tmr_ctl_reg, ic_mask_reg, ic_vector_reg;
   logic [15:0] rate_factor_reg, tmr0_count_reg, tmr1_count_reg;
   logic rd_data_valid_reg, rate_valid_reg, tmr0_valid_reg, tmr1_valid_reg;
   bdr_ser_cfg_t ser_cfg = '0;
   logic rx_line = 1'b1;
   logic tx_empty = 1'b1;
   logic ser_tick_reg, start_ok_reg, false_start_reg, tx_line_reg, sync_insert_reg;
   logic [4:0] frame_halfbits_reg;
   int tick_cnt = 0, ok_cnt = 0, fs_cnt = 0, si_cnt = 0;
   int error_cnt = 0;
   int cmp_count = 0;

   // ---------------------------------------------------------------
   // Design and processor
   // ---------------------------------------------------------------
   always #25 clk_sys = ~clk_sys;
   bdr_cpu_model bdr_cpu_model_i (.clk_sys, .cyc);
   bdr_decode bdr_decode_i (.clk_sys, .reset, .rom_large, .ram_bank, .cyc, .ser_cfg,
      .rx_line, .tx_empty, .sel_reg, .ic_target_reg, .rd_data_reg,
      .rd_data_valid_reg, .rate_factor_reg, .rate_valid_reg, .tmr0_count_reg,
      .tmr0_valid_reg, .tmr1_count_reg, .tmr1_valid_reg, .tmr_ctl_reg, .ic_mask_reg,
      .ic_vector_reg, .ser_tick_reg, .start_ok_reg, .false_start_reg, .tx_line_reg,
      .sync_insert_reg, .frame_halfbits_reg);

   // Serial pulses are tallied at the falling edge, where they have settled.
   always @(negedge clk_sys) begin
      tick_cnt <= tick_cnt + int'(ser_tick_reg);
      ok_cnt <= ok_cnt + int'(start_ok_reg);
      fs_cnt <= fs_cnt + int'(false_start_reg);
      si_cnt <= si_cnt + int'(sync_insert_reg);
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // One access then one idle cycle, so its answer is settled on return.
   task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      bdr_cpu_model_i.acc(k, a, d);
      bdr_cpu_model_i.idle();
   endtask
   task automatic ic_step(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d,
      input bdr_ic_target_t t);
      op(k, {8'h00, a}, d);
      `CHK("ic_target", t, ic_target_reg)
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // A hang costs a mismatch; the whole sequence needs about 9 us.
   initial begin
      #100us;
      error_cnt++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   // Straps change at a falling edge and get one idle cycle to settle.
   initial begin
      bdr_sel_t exp;
      logic [7:0] a;
      int n;
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      op(MR, 16'h0FFF, 8'h00); `CHK("rom", 1'b1, sel_reg.rom)
      op(MR, 16'h1000, 8'h00); `CHK("rom", 1'b0, sel_reg.rom)
      rom_large = 1'b1;
      op(MR, 16'h1FFF, 8'h00); `CHK("rom", 1'b1, sel_reg.rom)
      op(MR, 16'h2000, 8'h00); `CHK("rom", 1'b0, sel_reg.rom)
      op(MW, 16'h0000, 8'h00); `CHK("rom", 1'b0, sel_reg.rom)
      $display("rom test done");
      for (int b = 0; b < 4; b++) begin
         ram_bank = b[1:0];
         bdr_cpu_model_i.idle();
         op(MW, {b[1:0], 14'h3000}, 8'h00); `CHK("ram", 1'b1, sel_reg.ram)
         op(MR, {b[1:0], 14'h2FFF}, 8'h00); `CHK("ram", 1'b0, sel_reg.ram)
      end
      $display("ram test done");
      // Each write carries its own address as data, leaving the rate low byte pending.
      for (int i = 8'hD9; i <= 8'hE0; i++) begin
         a = i[7:0];
         exp = '0;
         exp.ic = a == BDR_IO_IC_A || a == BDR_IO_IC_B;
         exp.tmr0 = a == BDR_IO_TMR0;
         exp.tmr1 = a == BDR_IO_TMR1;
         exp.tctl = a == BDR_IO_TCTL;
         exp.rate = a == BDR_IO_RATE;
         op(IW, {8'h00, a}, a); `CHK("sel", exp, sel_reg)
      end
      `CHK("vector", 8'hDB, ic_vector_reg)
      `CHK("mask", 8'hFF, ic_mask_reg)
      `CHK("rate_valid", 1'b0, rate_valid_reg)
      $display("io decode test done");
      op(IW, 16'h00DE, 8'h12); `CHK("rate", 16'h12DE, rate_factor_reg)
      `CHK("rate_valid", 1'b1, rate_valid_reg)
      bdr_cpu_model_i.acc(IW, 16'h00DE, 8'h34);
      op(IW, 16'h00DE, 8'h56); `CHK("rate", 16'h5634, rate_factor_reg)
      op(IW, 16'h00DC, 8'h78);
      op(IW, 16'h00DF, 8'h3A); `CHK("tmr_ctl", 8'h3A, tmr_ctl_reg)
      bdr_cpu_model_i.acc(IW, 16'h00DC, 8'h11);
      op(IW, 16'h00DC, 8'h22); `CHK("tmr0", 16'h2211, tmr0_count_reg)
      `CHK("tmr0_valid", 1'b1, tmr0_valid_reg)
      bdr_cpu_model_i.acc(IW, 16'h00DD, 8'hAA);
      op(IW, 16'h00DD, 8'hBB); `CHK("tmr1", 16'hBBAA, tmr1_count_reg)
      $display("rate and timer test done");
      ic_step(IW, 8'hDA, 8'h10, BDR_IC_INIT);
      ic_step(IW, 8'hDB, 8'h40, BDR_IC_VECTOR);
      ic_step(IW, 8'hDB, 8'h5A, BDR_IC_MASK_WR);
      ic_step(IR, 8'hDB, 8'h00, BDR_IC_RD_MASK);
      `CHK("rd_valid", 1'b1, rd_data_valid_reg)
      `CHK("rd_data", 8'h5A, rd_data_reg)
      ic_step(IW, 8'hDA, 8'h0B, BDR_IC_CMD);
      ic_step(IR, 8'hDA, 8'h00, BDR_IC_RD_SVC);
      ic_step(IW, 8'hDA, 8'h0A, BDR_IC_CMD);
      ic_step(IR, 8'hDA, 8'h00, BDR_IC_RD_REQ);
      ic_step(IW, 8'hDA, 8'h0C, BDR_IC_CMD);
      ic_step(IR, 8'hDA, 8'h00, BDR_IC_RD_POLL);
      ic_step(IR, 8'hDA, 8'h00, BDR_IC_RD_REQ);
      `CHK("vector", 8'h40, ic_vector_reg)
      `CHK("mask", 8'h5A, ic_mask_reg)
      $display("controller test done");
      // A short factor of 8 gives a tick every 8 clocks and a half bit of 4.
      op(IW, 16'h00DE, 8'h08);
      op(IW, 16'h00DE, 8'h00); `CHK("rate", 16'h0008, rate_factor_reg)
      n = tick_cnt;
      repeat (32) @(negedge clk_sys);
      `CHK("ticks", 4, tick_cnt - n)
      rx_line = 1'b0;
      repeat (2) @(negedge clk_sys);
      rx_line = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK("false_start", 1, fs_cnt)
      `CHK("start_ok", 0, ok_cnt)
      rx_line = 1'b0;
      repeat (8) @(negedge clk_sys);
      rx_line = 1'b1;
      @(negedge clk_sys);
      `CHK("start_ok", 1, ok_cnt)
      `CHK("false_start", 1, fs_cnt)
      ser_cfg.char_len = 2'h3;
      ser_cfg.stop_sel = 2'h3;
      ser_cfg.brk = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK("tx_line", 1'b0, tx_line_reg)
      `CHK("frame", 5'h16, frame_halfbits_reg)
      ser_cfg.sync_mode = 1'b1;
      ser_cfg.char_len = 2'h0;
      repeat (2) @(negedge clk_sys);
      `CHK("tx_line", 1'b1, tx_line_reg)
      `CHK("frame", 5'h0A, frame_halfbits_reg)
      n = si_cnt;
      repeat (32) @(negedge clk_sys);
      `CHK("sync_insert", 4, si_cnt - n)
      $display("serial test done");
      give_verdict();
   end
endmodule
